/* File: design/pscr_pkg.sv */
// Purpose: shared constants and carriers for the synthesizer control block
// Assumes: 32-bit serial words, address in the low four bits
// Notes: field positions follow the configuration word layout
package pscr_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned NUM_WORDS = 14;
  localparam int unsigned SYS_CLK_MHZ = 50;
  localparam int unsigned LD_SLOW_DIV = 32;
  localparam logic [4:0] LD_SLOW_LAST = 5'h1f;
  // word addresses
  localparam logic [3:0] A_INT = 4'h0;
  localparam logic [3:0] A_MAIN_FRACTION_NUMERATOR = 4'h1;
  localparam logic [3:0] A_PHASE = 4'h2;
  localparam logic [3:0] A_AUX_FRACTION_NUMERATOR = 4'h3;
  localparam logic [3:0] A_AUX_MODULUS = 4'h4;
  localparam logic [3:0] A_RESYNC_FIRST_DIVIDER = 4'h5;
  localparam logic [3:0] A_PWR = 4'h6;
  localparam logic [3:0] A_LOCK = 4'h7;
  localparam logic [3:0] A_MON = 4'hc;
  // field positions
  localparam int unsigned INT_LSB = 4;
  localparam int unsigned INT_W = 16;
  localparam int unsigned MAIN_FRACTION_NUMERATOR_LSB = 4;
  localparam int unsigned MAIN_FRACTION_NUMERATOR_W = 25;
  localparam int unsigned AUX_LSB = 4;
  localparam int unsigned AUX_W = 24;
  localparam int unsigned PHASE_LSB = 4;
  localparam int unsigned PHASE_W = 12;
  localparam int unsigned RESYNC_FIRST_DIVIDER_LSB = 4;
  localparam int unsigned DIV_W = 12;
  localparam int unsigned RESYNC_SECOND_DIVIDER_LSB = 6;
  localparam int unsigned MODE_LSB = 18;
  localparam logic [1:0] MODE_RESYNC = 2'h2;
  localparam int unsigned LD_PRESET_LSB = 22;
  localparam int unsigned LD_PRESET_W = 8;
  localparam int unsigned LD_RATE_BIT = 30;
  localparam int unsigned PWDN_BIT = 6;
  localparam int unsigned INTMODE_BIT = 20;
  localparam int unsigned MON_LSB = 28;
  localparam int unsigned LEVEL_BIT = 27;
  localparam int unsigned MAIN_RST_BIT = 22;
  localparam int unsigned LE_SYNC_BIT = 20;
  localparam int unsigned RB_LSB = 14;
  localparam int unsigned RB_W = 6;
  localparam logic [3:0] MON_LOW = 4'h0;
  localparam logic [3:0] MON_LOCK = 4'h6;
  localparam logic [3:0] MON_SDO = 4'h7;
  localparam logic [3:0] MON_RB = 4'h8;
  localparam logic [3:0] MON_SYNC = 4'h9;
  localparam int unsigned RATIO_W = 66;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic [ADDR_W-1:0] addr;
  } pscr_word_s;

  typedef struct packed {
    logic [INT_W-1:0] int_word;
    logic [MAIN_FRACTION_NUMERATOR_W-1:0] main_fraction_numerator;
    logic [AUX_W-1:0] aux_fraction_numerator;
    logic [AUX_W-1:0] aux_modulus;
    logic int_mode;
  } pscr_div_s;
endpackage

/* File: design/pscr_link.sv */
// Purpose: three-wire serial receiver on the link clock
// Assumes: data sampled on rising link clock, msb first, load strobe low
// Notes: completed word crosses to sys_clk by toggle handshake
`timescale 1ns/1ps
module pscr_link (
  // link side
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic load_strobe,
  // system side
  input wire logic sys_clk,
  input wire logic rst_n,
  output pscr_pkg::pscr_word_s word,
  output logic word_pulse
);
  typedef struct packed {
    logic [pscr_pkg::WORD_W-1:0] shift;
    logic [pscr_pkg::WORD_W-1:0] held;
    logic le_q;
    logic tog;
  } pscr_lstate_s;

  typedef struct packed {
    logic [2:0] tog_sync;
    logic [pscr_pkg::WORD_W-1:0] held;
    logic pulse;
  } pscr_sstate_s;

  pscr_lstate_s l, next_l;
  pscr_sstate_s s, next_s;

  // ***********
  // link domain
  // ***********
  always_comb
  begin
    next_l = l;
    if (!load_strobe)
    begin
      next_l.shift = {l.shift[pscr_pkg::WORD_W-2:0], link_data};
    end
    next_l.le_q = load_strobe;
    // held word stays stable for a full handshake, host spaces strobes
    if (load_strobe && !l.le_q)
    begin
      next_l.held = l.shift;
      next_l.tog = ~l.tog;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      l <= '0;
    end
    else
    begin
      l <= next_l;
    end
  end

  // *************
  // system domain
  // *************
  always_comb
  begin
    next_s = s;
    next_s.tog_sync = {s.tog_sync[1:0], l.tog};
    next_s.pulse = s.tog_sync[2] ^ s.tog_sync[1];
    if (s.tog_sync[2] ^ s.tog_sync[1])
    begin
      next_s.held = l.held;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign word.data = s.held;
  assign word.addr = s.held[pscr_pkg::ADDR_W-1:0];
  assign word_pulse = s.pulse;
endmodule

/* File: design/pscr_resync.sv */
// Purpose: phase resync timer producing sync pulses
// Assumes: one comparison tick per reference falling edge
// Notes: period is first divider times second divider ticks
`timescale 1ns/1ps
module pscr_resync (
  // clocking
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic pfd_tick,
  input wire logic [pscr_pkg::DIV_W-1:0] div1,
  input wire logic [pscr_pkg::DIV_W-1:0] div2,
  // event
  output logic sync_pulse
);
  typedef struct packed {
    logic [pscr_pkg::DIV_W-1:0] c1;
    logic [pscr_pkg::DIV_W-1:0] c2;
    logic pulse;
  } pscr_tstate_s;

  pscr_tstate_s t, next_t;

  always_comb
  begin
    next_t = t;
    next_t.pulse = 1'b0;
    if (!enable)
    begin
      next_t.c1 = '0;
      next_t.c2 = '0;
    end
    else if (pfd_tick)
    begin
      // nested counters avoid a 24-bit multiplier
      if (t.c1 + 12'h001 >= div1)
      begin
        next_t.c1 = '0;
        if (t.c2 + 12'h001 >= div2)
        begin
          next_t.c2 = '0;
          next_t.pulse = 1'b1;
        end
        else
        begin
          next_t.c2 = t.c2 + 12'h001;
        end
      end
      else
      begin
        next_t.c1 = t.c1 + 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t <= '0;
    end
    else
    begin
      t <= next_t;
    end
  end

  assign sync_pulse = t.pulse;
endmodule

/* File: design/pscr_top.sv */
// Purpose: control side of a fractional-N synthesizer
// Assumes: host keeps its own programming rules
// Notes: ratio output is integer word scaled by two to the 49 plus the scaled fraction, which int mode clears
`timescale 1ns/1ps
module pscr_top (
  // system
  input wire logic sys_clk,
  input wire logic rst_n,
  // serial link
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic load_strobe,
  // reference and lock window
  input wire logic ref_in,
  input wire logic phase_in_window,
  // outputs
  output logic monitor_pin,
  output logic lock_indicator_pin,
  output logic logic_level_high,
  output logic power_down,
  output logic phase_realign,
  output logic [pscr_pkg::PHASE_W-1:0] phase_word,
  output logic [pscr_pkg::RATIO_W-1:0] div_ratio
);
  localparam int unsigned NW = pscr_pkg::NUM_WORDS;

  typedef struct packed {
    logic [NW-1:0][pscr_pkg::WORD_W-1:0] regs;
    logic [pscr_pkg::WORD_W-1:0] last_word;
    logic [pscr_pkg::WORD_W-1:0] sdo_shift;
    logic pend_valid;
    pscr_pkg::pscr_word_s pend;
    logic [2:0] ref_sync;
    logic [1:0] win_sync;
    logic [4:0] ld_div;
    logic [pscr_pkg::LD_PRESET_W-1:0] ld_cnt;
    logic locked;
    logic [1:0] sync_seen;
    logic armed;
    logic mon;
    logic lock_out;
    logic lvl;
    logic pwdn;
    logic realign;
    logic [pscr_pkg::PHASE_W-1:0] phase;
    logic [pscr_pkg::RATIO_W-1:0] ratio;
  } pscr_state_s;

  pscr_state_s r, next_r;
  pscr_pkg::pscr_word_s rx_word;
  logic rx_pulse;
  logic sync_pulse;
  logic pfd_tick;
  logic [pscr_pkg::WORD_W-1:0] w0, w1, w2, w3, w4, w5, w6, w7, w12;

  function automatic logic [pscr_pkg::WORD_W-1:0] rb_value(
    input logic [pscr_pkg::RB_W-1:0] sel,
    input logic [NW-1:0][pscr_pkg::WORD_W-1:0] regs,
    input logic locked
  );
    if (sel < 6'(NW))
    begin
      rb_value = regs[sel[3:0]];
    end
    else
    begin
      rb_value = {31'h0, locked};
    end
  endfunction

  function automatic logic [pscr_pkg::RATIO_W-1:0] calc_ratio(
    input pscr_pkg::pscr_div_s d
  );
    logic [pscr_pkg::RATIO_W-1:0] frac;
    frac = pscr_pkg::RATIO_W'(d.main_fraction_numerator) << pscr_pkg::AUX_W;
    if (d.aux_modulus != '0)
    begin
      frac = frac + pscr_pkg::RATIO_W'(
        (49'(d.aux_fraction_numerator) << pscr_pkg::AUX_W) / 49'(d.aux_modulus));
    end
    if (d.int_mode)
    begin
      frac = '0;
    end
    calc_ratio = (pscr_pkg::RATIO_W'(d.int_word)
      << (pscr_pkg::MAIN_FRACTION_NUMERATOR_W + pscr_pkg::AUX_W)) + frac;
  endfunction

  pscr_link u_link (
    .link_clk(link_clk),
    .link_data(link_data),
    .load_strobe(load_strobe),
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .word(rx_word),
    .word_pulse(rx_pulse)
  );

  assign w0 = r.regs[pscr_pkg::A_INT];
  assign w1 = r.regs[pscr_pkg::A_MAIN_FRACTION_NUMERATOR];
  assign w2 = r.regs[pscr_pkg::A_PHASE];
  assign w3 = r.regs[pscr_pkg::A_AUX_FRACTION_NUMERATOR];
  assign w4 = r.regs[pscr_pkg::A_AUX_MODULUS];
  assign w5 = r.regs[pscr_pkg::A_RESYNC_FIRST_DIVIDER];
  assign w6 = r.regs[pscr_pkg::A_PWR];
  assign w7 = r.regs[pscr_pkg::A_LOCK];
  assign w12 = r.regs[pscr_pkg::A_MON];
  // falling reference edge is the comparison tick
  assign pfd_tick = r.ref_sync[2] & ~r.ref_sync[1];

  pscr_resync u_resync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(w7[pscr_pkg::MODE_LSB +: 2] == pscr_pkg::MODE_RESYNC),
    .pfd_tick(pfd_tick),
    .div1(w5[pscr_pkg::RESYNC_FIRST_DIVIDER_LSB +: pscr_pkg::DIV_W]),
    .div2(w7[pscr_pkg::RESYNC_SECOND_DIVIDER_LSB +: pscr_pkg::DIV_W]),
    .sync_pulse(sync_pulse)
  );

  // ***********
  // next state
  // ***********
  always_comb
  begin
    pscr_pkg::pscr_div_s d;
    logic apply;
    logic lock_eval;
    logic raw_mon;
    logic [pscr_pkg::WORD_W-1:0] rb;
    d = '0;
    rb = '0;
    apply = 1'b0;
    lock_eval = 1'b0;
    raw_mon = 1'b0;
    next_r = r;
    next_r.ref_sync = {r.ref_sync[1:0], ref_in};
    next_r.win_sync = {r.win_sync[0], phase_in_window};
    next_r.realign = 1'b0;
    next_r.sdo_shift = {r.sdo_shift[pscr_pkg::WORD_W-2:0], 1'b0};
    if (rx_pulse)
    begin
      next_r.pend = rx_word;
      next_r.pend_valid = 1'b1;
    end
    // deferred to reference fall when strobe sync is set
    if (r.pend_valid && (!w12[pscr_pkg::LE_SYNC_BIT] || pfd_tick))
    begin
      apply = 1'b1;
      next_r.pend_valid = rx_pulse;
      next_r.regs[r.pend.addr] = r.pend.data;
      next_r.last_word = r.pend.data;
      next_r.sdo_shift = r.last_word;
      if (r.pend.addr == pscr_pkg::A_INT)
      begin
        next_r.armed = 1'b1;
        next_r.sync_seen = '0;
      end
      if (r.pend.addr == pscr_pkg::A_MON
          && r.pend.data[pscr_pkg::MAIN_RST_BIT])
      begin
        next_r.regs = '0;
        next_r.armed = 1'b0;
      end
    end
    // lock detector with preset and check rate
    if (pfd_tick)
    begin
      next_r.ld_div = r.ld_div + 5'h01;
      lock_eval = w7[pscr_pkg::LD_RATE_BIT]
        || (r.ld_div == pscr_pkg::LD_SLOW_LAST);
    end
    if (lock_eval)
    begin
      if (!r.win_sync[1])
      begin
        next_r.ld_cnt = w7[pscr_pkg::LD_PRESET_LSB +: pscr_pkg::LD_PRESET_W];
        next_r.locked = 1'b0;
      end
      else if (r.ld_cnt != '0)
      begin
        next_r.ld_cnt = r.ld_cnt - 8'h01;
      end
      else
      begin
        next_r.locked = 1'b1;
      end
    end
    if (w6[pscr_pkg::PWDN_BIT])
    begin
      next_r.locked = 1'b0;
      next_r.ld_cnt = w7[pscr_pkg::LD_PRESET_LSB +: pscr_pkg::LD_PRESET_W];
    end
    // second sync after load realigns, later ones ignored
    if (sync_pulse && r.armed && !apply)
    begin
      next_r.sync_seen = r.sync_seen + 2'h1;
      if (r.sync_seen == 2'h1)
      begin
        next_r.realign = 1'b1;
        next_r.armed = 1'b0;
      end
    end
    // a call result cannot be bit-selected, so it lands in rb first
    rb = rb_value(w12[pscr_pkg::RB_LSB +: pscr_pkg::RB_W], r.regs,
      r.locked);
    unique case (w12[pscr_pkg::MON_LSB +: 4])
      pscr_pkg::MON_LOCK: raw_mon = r.locked;
      pscr_pkg::MON_SDO: raw_mon = r.sdo_shift[pscr_pkg::WORD_W-1];
      pscr_pkg::MON_RB: raw_mon = rb[r.ld_div];
      pscr_pkg::MON_SYNC: raw_mon = sync_pulse;
      default: raw_mon = 1'b0;
    endcase
    next_r.mon = raw_mon;
    next_r.lock_out = r.locked;
    next_r.lvl = w12[pscr_pkg::LEVEL_BIT];
    next_r.pwdn = w6[pscr_pkg::PWDN_BIT];
    next_r.phase = w2[pscr_pkg::PHASE_LSB +: pscr_pkg::PHASE_W];
    d.int_word = w0[pscr_pkg::INT_LSB +: pscr_pkg::INT_W];
    d.main_fraction_numerator = w1[pscr_pkg::MAIN_FRACTION_NUMERATOR_LSB +: pscr_pkg::MAIN_FRACTION_NUMERATOR_W];
    d.aux_fraction_numerator = w3[pscr_pkg::AUX_LSB +: pscr_pkg::AUX_W];
    d.aux_modulus = w4[pscr_pkg::AUX_LSB +: pscr_pkg::AUX_W];
    d.int_mode = w6[pscr_pkg::INTMODE_BIT];
    next_r.ratio = calc_ratio(d);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign monitor_pin = r.mon;
  assign lock_indicator_pin = r.lock_out;
  assign logic_level_high = r.lvl;
  assign power_down = r.pwdn;
  assign phase_realign = r.realign;
  assign phase_word = r.phase;
  assign div_ratio = r.ratio;

  // ***********
  // assertions
  // ***********
  sequence s_main_reset;
    r.pend_valid && !w12[pscr_pkg::LE_SYNC_BIT]
      && r.pend.addr == pscr_pkg::A_MON
      && r.pend.data[pscr_pkg::MAIN_RST_BIT];
  endsequence

  AST_MAIN_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_main_reset |=> (r.regs == '0))
    else $error("main reset did not clear words");

  AST_DEFER_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.pend_valid && w12[pscr_pkg::LE_SYNC_BIT] && !pfd_tick && !rx_pulse)
      |=> r.pend_valid)
    else $error("load applied without reference fall");

  AST_ASYNC_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.pend_valid && !w12[pscr_pkg::LE_SYNC_BIT] && !rx_pulse)
      |=> !r.pend_valid && r.last_word == $past(r.pend.data))
    else $error("async load not applied next cycle");

  AST_ECHO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.pend_valid && !w12[pscr_pkg::LE_SYNC_BIT])
      |=> r.sdo_shift == $past(r.last_word))
    else $error("echo word not previous write");

  AST_LOCK_DROP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    w6[pscr_pkg::PWDN_BIT] |=> !r.locked ##1 !lock_indicator_pin)
    else $error("lock shown while powered down");

  AST_SLOW_RATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pfd_tick && !w7[pscr_pkg::LD_RATE_BIT] && r.ld_div != 5'h1f
      && !w6[pscr_pkg::PWDN_BIT]) |=> $stable(r.ld_cnt))
    else $error("lock evaluated off the 32nd cycle");

  AST_REALIGN_ONCE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    phase_realign |=> !r.armed && !phase_realign)
    else $error("realign repeated");

  AST_REALIGN_SECOND: assert property (@(posedge sys_clk) disable iff (!rst_n)
    phase_realign |-> $past(r.sync_seen) == 2'h1 && $past(sync_pulse))
    else $error("realign not on second sync");

  AST_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 logic_level_high == $past(w12[pscr_pkg::LEVEL_BIT]))
    else $error("logic level not following word twelve");
endmodule

/* File: dv/pscr_host.sv */
// Purpose: host model driving the three-wire programming link
// Assumes: link clock 48 ns, running inside a frame plus one cycle after strobe rise
// Notes: data line carries no pull, so idle shows the inverted last bit
`timescale 1ns/1ps
module pscr_host (
  // link
  output logic link_clk,
  output logic link_data,
  output logic load_strobe
);
  initial
  begin
    link_clk = 1'b0;
    link_data = 1'b0;
    load_strobe = 1'b1;
  end

  // ****************************
  // one framed word, msb first
  // ****************************
  task automatic send(input logic [31:0] w);
    #7;
    load_strobe = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      link_data = w[i];
      #24 link_clk = 1'b1;
      #24 link_clk = 1'b0;
    end
    // word only taken by a link edge after strobe rise
    load_strobe = 1'b1;
    #24 link_clk = 1'b1;
    #24 link_clk = 1'b0;
    link_data = ~w[0];
  endtask
endmodule

/* File: dv/test_pscr_top.sv */
// Purpose: self-checking bench for the synthesizer control block
// Assumes: reference is sys_clk divided by 8, falling tick at count 4
// Notes: every scenario is one task, checked before it returns
`timescale 1ns/1ps
module test_pscr_top;
  logic sys_clk, rst_n, ref_run, phase_in_window, ref_in;
  logic link_clk, link_data, load_strobe;
  logic monitor_pin, lock_indicator_pin, logic_level_high;
  logic power_down, phase_realign;
  logic [pscr_pkg::PHASE_W-1:0] phase_word;
  logic [pscr_pkg::RATIO_W-1:0] div_ratio;
  logic [2:0] ref_cnt;
  int miscompares, comparisons;
  localparam logic [65:0] R_INT = 66'h5b << 49;
  localparam logic [65:0] R_FRAC = R_INT + (66'ha3d70 << 24)
    + ((66'h40 << 24) / 66'h64);
  // bias field 0b10 at bits 5:4 of word seven; block ignores it
  localparam logic [31:0] PS_BIAS = 32'h0000_0020;

  pscr_host host (.link_clk(link_clk), .link_data(link_data),
    .load_strobe(load_strobe));
  pscr_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
    .link_data(link_data), .load_strobe(load_strobe), .ref_in(ref_in),
    .phase_in_window(phase_in_window), .monitor_pin(monitor_pin),
    .lock_indicator_pin(lock_indicator_pin),
    .logic_level_high(logic_level_high), .power_down(power_down),
    .phase_realign(phase_realign), .phase_word(phase_word),
    .div_ratio(div_ratio));

  // ****************************
  // clocks
  // ****************************
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // reference can be stopped to hold off synchronised loads
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      ref_cnt <= 3'h0;
    else if (ref_run)
      ref_cnt <= ref_cnt + 3'h1;
  assign ref_in = ~ref_cnt[2];

  // ****************************
  // helpers
  // ****************************
  task automatic chk(input string n, input logic [65:0] e,
    input logic [65:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // strobes kept well over 8 sys_clk apart
  task automatic wr(input logic [31:0] w);
    host.send(w);
    repeat (20) @(posedge sys_clk);
  endtask

  // counts rising edges of the monitor pin or the realign pulse
  task automatic rises(input bit rl, input int n, output int c);
    logic p, s;
    c = 0;
    p = 1'b1;
    repeat (n)
    begin
      @(negedge sys_clk);
      s = rl ? phase_realign : monitor_pin;
      if (s === 1'b1 && p === 1'b0)
        c++;
      p = s;
    end
  endtask

  task automatic next_rise(output int t);
    logic p;
    t = 0;
    p = monitor_pin;
    while (!(monitor_pin === 1'b1 && p === 1'b0))
    begin
      p = monitor_pin;
      @(negedge sys_clk);
      t++;
      if (t > 300)
      begin
        miscompares++;
        results();
      end
    end
  endtask

  // ****************************
  // scenarios
  // ****************************
  task automatic t_init;
    logic [31:0] iw [14];
    iw = '{32'h0000_05b0, 32'h00a3_d701, 32'h0000_0002, 32'h0000_0403,
      32'h0000_0644, 32'h0000_0005, 32'h0000_0006, 32'h0000_0007 | PS_BIAS,
      32'h0000_0008, 32'h0000_0009, 32'h0000_000a, 32'h8000_000b,
      32'h0000_000c, 32'h0000_000d};
    for (int i = 13; i >= 0; i--)
      wr(iw[i]);
    chk("ratio", R_FRAC, div_ratio);
    wr(32'h0010_0006);
    chk("int ratio", R_INT, div_ratio);
    wr(32'h0010_0046);
    chk("pwdn", 66'h1, 66'(power_down));
    chk("kept", R_INT, div_ratio);
    wr(32'h0000_0006);
    chk("pwup", 66'h0, 66'(power_down));
  endtask

  task automatic t_level;
    wr(32'h0800_000c);
    chk("level", 66'h1, 66'(logic_level_high));
    wr(32'h0000_abc2);
    chk("phase", 66'habc, 66'(phase_word));
  endtask

  task automatic t_echo;
    logic [31:0] h;
    bit f;
    h = 32'h0;
    f = 1'b0;
    wr(32'h7000_000c);
    host.send(32'h0000_5552);
    repeat (90)
    begin
      @(negedge sys_clk);
      h = {h[30:0], monitor_pin};
      if (h === 32'h7000_000c)
        f = 1'b1;
    end
    chk("echo", 66'h1, 66'(f));
  endtask

  task automatic t_lock;
    phase_in_window <= 1'b0;
    wr(32'h0100_0007 | PS_BIAS);
    repeat (320) @(posedge sys_clk);
    phase_in_window <= 1'b1;
    repeat (80) @(posedge sys_clk);
    chk("slow lock", 66'h0, 66'(lock_indicator_pin));
    wr(32'h4100_0007 | PS_BIAS);
    repeat (80) @(posedge sys_clk);
    chk("fast lock", 66'h1, 66'(lock_indicator_pin));
    wr(32'h6000_000c);
    chk("mon lock", 66'h1, 66'(monitor_pin));
  endtask

  task automatic t_resync;
    int t, c;
    // short period chosen, no real loop to settle here
    wr(32'h0000_0025);
    wr(32'h0008_00c7 | PS_BIAS);
    wr(32'h9000_000c);
    next_rise(t);
    next_rise(t);
    chk("sync gap", 66'd48, 66'(t));
    wr(32'h0000_05b0);
    rises(1'b1, 300, c);
    chk("realign", 66'h1, 66'(c));
    wr(32'h0000_00c7 | PS_BIAS);
    rises(1'b0, 150, c);
    chk("no sync", 66'h0, 66'(c));
  endtask

  task automatic t_lesync;
    wr(32'h0010_000c);
    ref_run <= 1'b0;
    wr(32'h0000_1232);
    chk("held", 66'h555, 66'(phase_word));
    ref_run <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chk("loaded", 66'h123, 66'(phase_word));
    wr(32'h0000_000c);
  endtask

  task automatic t_reset;
    wr(32'h0040_000c);
    chk("rst phase", 66'h0, 66'(phase_word));
    chk("rst ratio", 66'h0, div_ratio);
  endtask

  // select above the word count reads the lock flag, one bit per tick
  task automatic t_readback;
    int t;
    wr(32'h800f_c00c);
    next_rise(t);
    next_rise(t);
    chk("rb gap", 66'd256, 66'(t));
  endtask

  // ****************************
  // main sequence
  // ****************************
  initial
  begin
    #1000000;
    miscompares++;
    results();
  end

  initial
  begin
    rst_n = 1'b0;
    ref_run = 1'b1;
    phase_in_window = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_init();
    t_level();
    t_echo();
    t_lock();
    t_resync();
    t_lesync();
    t_reset();
    t_readback();
    results();
  end
endmodule
